/* File: src/bcr_map.svh */
// register offsets, field positions, reset values and codes of the bias link
`ifndef BCR_MAP_SVH
`define BCR_MAP_SVH

// fixed upper four bits of the 7-bit slave address
`define BCR_ADDR_HI        4'h4

// register select codes carried in the low nibble of the command byte
`define BCR_SEL_HI_CH1     4'h0
`define BCR_SEL_HI_CH2     4'h1
`define BCR_SEL_LO_CH1     4'h2
`define BCR_SEL_LO_CH2     4'h3
`define BCR_SEL_FINE_CH1   4'h4
`define BCR_SEL_FINE_CH2   4'h5
`define BCR_SEL_QUEUE      4'h6

// field positions of data words
`define BCR_COARSE_MSB     7
`define BCR_FINE_MSB       9
`define BCR_TAG_MSB        15
`define BCR_TAG_LSB        12
`define BCR_RESULT_MSB     11

// reset values
`define BCR_COARSE_RST     8'h00
`define BCR_FINE_RST       10'h000
`define BCR_SEL_RST        4'h0

// queue tags
`define BCR_SRC_RESERVED   3'h7
`define BCR_TAG_CORRUPT    4'hE
`define BCR_TAG_EMPTY      4'hF

// bits per byte on the wire
`define BCR_LAST_BIT       4'h7
`define BCR_BYTE_BITS      4'h8

`endif

/* File: src/bcr_pkg.sv */
// types shared by the bias controller serial access logic
package bcr_pkg;

  // serial slave sequencer, codes gray ordered as declared; hops from ST_WHI and ST_ACK_RX into ST_ACK_TX and on to ST_WHI or ST_RD flip more than one bit
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_ADDR   = 4'h1,
    ST_ACK_TX = 4'h3,
    ST_CMD    = 4'h2,
    ST_WHI    = 4'h6,
    ST_WLO    = 4'h7,
    ST_RD     = 4'h5,
    ST_ACK_RX = 4'h4,
    ST_WAIT   = 4'hC
  } bcr_state_type;

  // one conversion result with its 3-bit source code
  typedef struct packed {
    logic [2:0]  src;
    logic [11:0] result;
  } bcr_conv_type;

  // write-through event handed to the dac side
  typedef struct packed {
    logic        valid;
    logic [3:0]  sel;
    logic [15:0] data;
  } bcr_wr_type;

endpackage

/* File: src/bcr_fifo.sv */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module bcr_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("bcr_fifo: depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             full_q;
  logic             empty_q;

  wire push = in_valid & ~full_q;
  wire pop  = out_ready & ~empty_q;
  wire [AW:0] wr_d = push ? wr_q + 1'b1 : wr_q;
  wire [AW:0] rd_d = pop  ? rd_q + 1'b1 : rd_q;

  assign in_ready  = ~full_q;
  assign out_valid = ~empty_q;
  assign out_data  = mem[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  // flags are registered so the ready seen outside comes from a flop
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_q    <= '0;
      rd_q    <= '0;
      full_q  <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      full_q  <= (wr_d[AW] != rd_d[AW]) && (wr_d[AW-1:0] == rd_d[AW-1:0]);
      empty_q <= (wr_d == rd_d);
    end
  end
endmodule

/* File: src/bcr_serial_access.sv */
// two-wire slave register access of the dual-channel bias controller
//
// Functional notes
// [R1] coarse high wiper: 8-bit code, reset zero
// [R2] coarse low wiper: 8-bit code, reset zero
// [R3] fine calibrated code: 10 bits, reset zero
// [R4] command byte after address is acknowledged
// [R5] upper data byte msb first, acknowledged
// [R6] lower data byte acknowledged, completes write
// [R7] master ends single write with restart/stop
// [R8] block write: repeated groups, each written
// [R9] read opens on start or restart
// [R10] five-byte read uses command sent within
// [R11] three-byte read uses last accessed register
// [R12] write address, command, restart, read address
// [R13] read sends upper byte first, msb first
// [R14] after master ack, send lower byte
// [R15] queue word: 4-bit tag, 12-bit result
// [R16] overflow during readout gives tag 1110
// [R17] empty queue read: tag 1111 plus flags
// [R18] write opens with address, direction zero
// [R19] master ack keeps words flowing, nack ends
// [R20] address: fixed upper nibble plus three straps
// [R21] tags 0111 to 1101 never produced
// [R22] empty read keeps pointers; read pops oldest
`timescale 1ns/1ps
`include "bcr_map.svh"
module bcr_serial_access #(
  parameter int QUEUE_DEPTH = 8
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_n,
  input  wire logic               addr_strap_bit2,
  input  wire logic               addr_strap_bit1,
  input  wire logic               addr_strap_bit0,
  input  wire bcr_pkg::bcr_conv_type conv_in,
  input  wire logic               conv_valid,
  output logic                    conv_ready,
  input  wire logic [11:0]        flag_in,
  output logic                    queue_pop,
  output logic                    queue_ovf,
  output logic                    queue_empty,
  output logic [7:0]              coarse_high_writethru_ch1,
  output logic [7:0]              coarse_high_writethru_ch2,
  output logic [7:0]              coarse_low_writethru_ch1,
  output logic [7:0]              coarse_low_writethru_ch2,
  output logic [9:0]              fine_writethru_calib_ch1,
  output logic [9:0]              fine_writethru_calib_ch2,
  output bcr_pkg::bcr_wr_type     wr_evt
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  bcr_pkg::bcr_state_type state_q;
  bcr_pkg::bcr_state_type nxt_q;
  logic        scl_q;
  logic        sda_q;
  logic        scl_p;
  logic        sda_p;
  logic        ack_ph_q;
  logic [3:0]  bit_q;
  logic [7:0]  rx_q;
  logic [7:0]  tx_q;
  logic [7:0]  lo_save_q;
  logic        lo_phase_q;
  logic [3:0]  sel_q;
  logic [7:0]  hi_q;
  logic [2:0]  strap_q;
  logic        strap_vld_q;
  logic        sda_oe_n_q;
  logic        sda_o_q;
  logic        pop_q;
  logic        ovf_q;
  logic [7:0]  c_hi1_q;
  logic [7:0]  c_hi2_q;
  logic [7:0]  c_lo1_q;
  logic [7:0]  c_lo2_q;
  logic [9:0]  f1_q;
  logic [9:0]  f2_q;
  bcr_pkg::bcr_wr_type wr_q;

  // ---------------------------------------------------------------
  // line events
  // ---------------------------------------------------------------
  wire scl_rise = scl_q & ~scl_p;
  wire scl_fall = ~scl_q & scl_p;
  // start and repeated start look alike, so reads open on either [R9]
  wire start_c  = scl_q & scl_p & sda_p & ~sda_q;
  wire stop_c   = scl_q & scl_p & ~sda_p & sda_q;

  wire       st_rx    = (state_q == bcr_pkg::ST_ADDR) ||
                        (state_q == bcr_pkg::ST_CMD) ||
                        (state_q == bcr_pkg::ST_WHI) ||
                        (state_q == bcr_pkg::ST_WLO);
  wire [7:0] rx_byte  = {rx_q[6:0], sda_q};
  wire       byte_done = st_rx & scl_rise & (bit_q == `BCR_LAST_BIT);
  wire [6:0] own_addr = {`BCR_ADDR_HI, strap_q};
  wire       addr_hit = strap_vld_q & (rx_byte[7:1] == own_addr); // [R20]
  wire       in_addr  = (state_q == bcr_pkg::ST_ADDR) & byte_done;
  wire       rd_open  = in_addr & addr_hit & rx_byte[0];
  wire       wr_open  = in_addr & addr_hit & ~rx_byte[0]; // [R18]
  wire       master_ack = (state_q == bcr_pkg::ST_ACK_RX) & scl_rise &
                          ~sda_q;
  wire       master_nack = (state_q == bcr_pkg::ST_ACK_RX) & scl_rise &
                           sda_q;
  // a fresh word is fetched at read open and after the low byte is acked
  wire       load_word = rd_open | (master_ack & lo_phase_q); // [R19]
  wire       wr_fire   = (state_q == bcr_pkg::ST_WLO) & byte_done; // [R6]
  wire [15:0] wr_word  = {hi_q, rx_byte};

  // ---------------------------------------------------------------
  // conversion queue
  // ---------------------------------------------------------------
  bcr_pkg::bcr_conv_type q_out;
  logic       q_valid;
  logic       q_in_ready;
  // the reserved source code is dropped so no reserved tag leaves [R21]
  wire        src_ok   = conv_in.src != `BCR_SRC_RESERVED; // [R21]
  wire        q_push   = conv_valid & src_ok;
  wire        ovf_now  = q_push & ~q_in_ready;
  wire        sel_q_is = (sel_q == `BCR_SEL_QUEUE);
  // pop only when something is there; empty reads leave pointers [R22]
  wire        q_pop    = load_word & sel_q_is & q_valid; // [R22]
  wire [3:0]  q_tag    = (ovf_now & q_pop) ? `BCR_TAG_CORRUPT :
                         {1'b0, q_out.src}; // [R16]
  wire [15:0] q_word   = q_valid ? {q_tag, q_out.result} :
                         {`BCR_TAG_EMPTY, flag_in}; // [R15] [R17]

  bcr_fifo #(
    .WIDTH ($bits(bcr_pkg::bcr_conv_type)),
    .DEPTH (QUEUE_DEPTH)
  ) u_queue (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (q_push),
    .in_ready  (q_in_ready),
    .in_data   (conv_in),
    .out_valid (q_valid),
    .out_ready (q_pop),
    .out_data  (q_out)
  );

  // ---------------------------------------------------------------
  // read word selection
  // ---------------------------------------------------------------
  // the last selected register is read, whether selected in this
  // transfer or an earlier one [R10] [R11]
  wire [15:0] rd_word =
    (sel_q == `BCR_SEL_HI_CH1)   ? {8'h00, c_hi1_q} :
    (sel_q == `BCR_SEL_HI_CH2)   ? {8'h00, c_hi2_q} :
    (sel_q == `BCR_SEL_LO_CH1)   ? {8'h00, c_lo1_q} :
    (sel_q == `BCR_SEL_LO_CH2)   ? {8'h00, c_lo2_q} :
    (sel_q == `BCR_SEL_FINE_CH1) ? {6'h00, f1_q} :
    (sel_q == `BCR_SEL_FINE_CH2) ? {6'h00, f2_q} :
    sel_q_is                     ? q_word : 16'h0000;

  // ---------------------------------------------------------------
  // line sampling and address straps
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      scl_p <= scl_q;
      sda_p <= sda_q;
    end
  end

  // straps are caught once, on the first edge after reset release
  always_ff @(posedge clk) begin
    if (!nrst) begin
      strap_vld_q <= 1'b0;
      strap_q     <= 3'h0;
    end else if (!strap_vld_q) begin
      strap_vld_q <= 1'b1;
      strap_q     <= {addr_strap_bit2, addr_strap_bit1,
                      addr_strap_bit0}; // [R20]
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q    <= bcr_pkg::ST_IDLE;
      nxt_q      <= bcr_pkg::ST_IDLE;
      ack_ph_q   <= 1'b0;
      bit_q      <= 4'h0;
      rx_q       <= 8'h00;
      sda_oe_n_q <= 1'b1;
    end else if (start_c) begin
      state_q    <= bcr_pkg::ST_ADDR; // [R9]
      bit_q      <= 4'h0;
      sda_oe_n_q <= 1'b1;
    end else if (stop_c) begin
      state_q    <= bcr_pkg::ST_IDLE;
      sda_oe_n_q <= 1'b1;
    end else begin
      case (state_q)
        bcr_pkg::ST_ADDR, bcr_pkg::ST_CMD,
        bcr_pkg::ST_WHI, bcr_pkg::ST_WLO: begin
          if (scl_rise) begin
            rx_q  <= rx_byte;
            bit_q <= bit_q + 4'h1;
          end
          if (byte_done) begin
            ack_ph_q <= 1'b0;
            bit_q    <= 4'h0;
            case (state_q)
              bcr_pkg::ST_ADDR: begin
                if (addr_hit) begin
                  state_q <= bcr_pkg::ST_ACK_TX;
                  nxt_q   <= rx_byte[0] ? bcr_pkg::ST_RD :
                             bcr_pkg::ST_CMD; // [R4] [R12]
                end else begin
                  state_q <= bcr_pkg::ST_WAIT;
                end
              end
              bcr_pkg::ST_CMD: begin
                state_q <= bcr_pkg::ST_ACK_TX;
                nxt_q   <= bcr_pkg::ST_WHI; // [R4] [R5]
              end
              bcr_pkg::ST_WHI: begin
                state_q <= bcr_pkg::ST_ACK_TX;
                nxt_q   <= bcr_pkg::ST_WLO; // [R5] [R6]
              end
              default: begin
                // back to a command byte so a block write continues [R8]
                state_q <= bcr_pkg::ST_ACK_TX;
                nxt_q   <= bcr_pkg::ST_CMD; // [R8]
              end
            endcase
          end
        end
        bcr_pkg::ST_ACK_TX: begin
          if (scl_fall) begin
            if (!ack_ph_q) begin
              ack_ph_q   <= 1'b1;
              sda_oe_n_q <= 1'b0;
            end else begin
              state_q    <= nxt_q;
              bit_q      <= 4'h0;
              // a read drives its first bit on the same falling edge
              sda_oe_n_q <= (nxt_q == bcr_pkg::ST_RD) ? tx_q[7] : 1'b1;
            end
          end
        end
        bcr_pkg::ST_RD: begin
          if (scl_rise) begin
            bit_q <= bit_q + 4'h1;
          end
          if (scl_fall) begin
            if (bit_q == `BCR_BYTE_BITS) begin
              state_q    <= bcr_pkg::ST_ACK_RX;
              sda_oe_n_q <= 1'b1;
            end else begin
              sda_oe_n_q <= tx_q[7]; // [R13] [R14]
            end
          end
        end
        bcr_pkg::ST_ACK_RX: begin
          if (master_ack) begin
            state_q  <= bcr_pkg::ST_ACK_TX;
            nxt_q    <= bcr_pkg::ST_RD; // [R14] [R19]
            ack_ph_q <= 1'b1;
          end else if (master_nack) begin
            state_q <= bcr_pkg::ST_WAIT; // [R19]
          end
        end
        bcr_pkg::ST_IDLE, bcr_pkg::ST_WAIT: begin
          sda_oe_n_q <= 1'b1;
        end
        default: begin
          state_q    <= bcr_pkg::ST_IDLE;
          sda_oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // transmit byte path
  // ---------------------------------------------------------------
  wire tx_shift = (state_q == bcr_pkg::ST_RD) & scl_fall &
                  (bit_q != `BCR_BYTE_BITS);
  wire first_bit = (state_q == bcr_pkg::ST_ACK_TX) & scl_fall & ack_ph_q &
                   (nxt_q == bcr_pkg::ST_RD);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_q       <= 8'h00;
      lo_save_q  <= 8'h00;
      lo_phase_q <= 1'b0;
    end else if (load_word) begin
      tx_q       <= rd_word[15:8]; // [R13]
      lo_save_q  <= rd_word[7:0];
      lo_phase_q <= 1'b0;
    end else if (master_ack) begin
      tx_q       <= lo_save_q; // [R14]
      lo_phase_q <= 1'b1;
    end else if (tx_shift | first_bit) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // command and data capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sel_q <= `BCR_SEL_RST;
      hi_q  <= 8'h00;
    end else if ((state_q == bcr_pkg::ST_CMD) & byte_done) begin
      sel_q <= rx_byte[3:0]; // [R4] [R10]
    end else if ((state_q == bcr_pkg::ST_WHI) & byte_done) begin
      hi_q <= rx_byte; // [R5]
    end
  end

  // ---------------------------------------------------------------
  // write-through registers
  // ---------------------------------------------------------------
  wire w_hi1 = wr_fire & (sel_q == `BCR_SEL_HI_CH1);
  wire w_hi2 = wr_fire & (sel_q == `BCR_SEL_HI_CH2);
  wire w_lo1 = wr_fire & (sel_q == `BCR_SEL_LO_CH1);
  wire w_lo2 = wr_fire & (sel_q == `BCR_SEL_LO_CH2);
  wire w_f1  = wr_fire & (sel_q == `BCR_SEL_FINE_CH1);
  wire w_f2  = wr_fire & (sel_q == `BCR_SEL_FINE_CH2);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      c_hi1_q <= `BCR_COARSE_RST; // [R1]
      c_hi2_q <= `BCR_COARSE_RST; // [R1]
      c_lo1_q <= `BCR_COARSE_RST; // [R2]
      c_lo2_q <= `BCR_COARSE_RST; // [R2]
    end else begin
      if (w_hi1) c_hi1_q <= wr_word[`BCR_COARSE_MSB:0]; // [R1]
      if (w_hi2) c_hi2_q <= wr_word[`BCR_COARSE_MSB:0]; // [R1]
      if (w_lo1) c_lo1_q <= wr_word[`BCR_COARSE_MSB:0]; // [R2]
      if (w_lo2) c_lo2_q <= wr_word[`BCR_COARSE_MSB:0]; // [R2]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      f1_q <= `BCR_FINE_RST; // [R3]
      f2_q <= `BCR_FINE_RST; // [R3]
    end else begin
      if (w_f1) f1_q <= wr_word[`BCR_FINE_MSB:0]; // [R3]
      if (w_f2) f2_q <= wr_word[`BCR_FINE_MSB:0]; // [R3]
    end
  end

  // every accepted word is announced, unmapped selects included, so the
  // dac side decides on side effects
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_q <= '0;
    end else begin
      wr_q.valid <= wr_fire; // [R6] [R8]
      wr_q.sel   <= sel_q;
      wr_q.data  <= wr_word;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pop_q   <= 1'b0;
      ovf_q   <= 1'b0;
      sda_o_q <= 1'b0;
    end else begin
      pop_q   <= q_pop;
      ovf_q   <= ovf_now;
      sda_o_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign sda_o                     = sda_o_q;
  assign sda_oe_n                  = sda_oe_n_q;
  assign conv_ready                = q_in_ready;
  assign queue_pop                 = pop_q;
  assign queue_ovf                 = ovf_q;
  assign queue_empty               = ~q_valid;
  assign coarse_high_writethru_ch1 = c_hi1_q;
  assign coarse_high_writethru_ch2 = c_hi2_q;
  assign coarse_low_writethru_ch1  = c_lo1_q;
  assign coarse_low_writethru_ch2  = c_lo2_q;
  assign fine_writethru_calib_ch1  = f1_q;
  assign fine_writethru_calib_ch2  = f2_q;
  assign wr_evt                    = wr_q;

endmodule

/* File: bench/bcr_serial_access_properties.sv */
// port checks of the serial register access block
`timescale 1ns/1ps
`include "bcr_map.svh"
module bcr_serial_access_properties (
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire logic                  scl_i,
  input wire logic                  sda_oe_n,
  input wire bcr_pkg::bcr_conv_type conv_in,
  input wire logic                  conv_valid,
  input wire logic                  conv_ready,
  input wire logic                  queue_pop,
  input wire logic                  queue_ovf,
  input wire logic                  queue_empty,
  input wire logic [7:0]            coarse_high_writethru_ch1,
  input wire logic [7:0]            coarse_low_writethru_ch2,
  input wire logic [9:0]            fine_writethru_calib_ch1,
  input wire bcr_pkg::bcr_wr_type   wr_evt
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  hi_ch1_load_a: assert property (wr_evt.valid && wr_evt.sel ==
    `BCR_SEL_HI_CH1 |=> coarse_high_writethru_ch1 == $past(wr_evt.data[7:0]))
    else $error("coarse high ch1 not loaded from write");
  lo_ch2_load_a: assert property (wr_evt.valid && wr_evt.sel ==
    `BCR_SEL_LO_CH2 |=> coarse_low_writethru_ch2 == $past(wr_evt.data[7:0]))
    else $error("coarse low ch2 not loaded from write");
  fine_ch1_load_a: assert property (wr_evt.valid && wr_evt.sel ==
    `BCR_SEL_FINE_CH1 |=> fine_writethru_calib_ch1 == $past(wr_evt.data[9:0]))
    else $error("fine ch1 not loaded from write");
  // the code and the write event leave their flops on the same edge
  fine_hold_a: assert property ($changed(fine_writethru_calib_ch1)
    |-> wr_evt.valid) else $error("fine ch1 moved without a write");
  write_pulse_a: assert property (wr_evt.valid |=> !wr_evt.valid)
    else $error("write event longer than one cycle");
  sda_low_phase_a: assert property ($changed(sda_oe_n) |-> !scl_i)
    else $error("data line moved while bus clock high");
  ovf_cause_a: assert property (conv_valid && !conv_ready &&
    conv_in.src != `BCR_SRC_RESERVED |=> queue_ovf)
    else $error("overflow not flagged");
  ovf_only_a: assert property (queue_ovf |->
    $past(conv_valid) && !$past(conv_ready))
    else $error("overflow flagged without a push into full queue");
  full_not_empty_a: assert property (!conv_ready |-> !queue_empty)
    else $error("queue full and empty at once");
  pop_nonempty_a: assert property (queue_pop |-> !$past(queue_empty))
    else $error("pop from an empty queue");
endmodule

bind bcr_serial_access bcr_serial_access_properties chk (.clk, .nrst,
  .scl_i, .sda_oe_n, .conv_in, .conv_valid, .conv_ready, .queue_pop,
  .queue_ovf, .queue_empty, .coarse_high_writethru_ch1,
  .coarse_low_writethru_ch2, .fine_writethru_calib_ch1, .wr_evt);

/* File: bench/bcr_bus_master.sv */
// two-wire bus master model facing the serial access block
`timescale 1ns/1ps
module bcr_bus_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  // ----------------------------------------------------------------
  // bit and byte framing
  // ----------------------------------------------------------------
  // half bus period in clocks; raised by the bench for a slow master
  int half = 6;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // data moves one clock after the scl fall, never in the same step
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    hold(half);
    scl = 1'b1;
    hold(half);
    r = sda;
    scl = 1'b0;
    hold(1);
  endtask
  task automatic start();
    sda_drv = 1'b1;
    hold(half);
    scl = 1'b1;
    hold(half);
    sda_drv = 1'b0;
    hold(half);
    scl = 1'b0;
    hold(half);
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    hold(half);
    scl = 1'b1;
    hold(half);
    sda_drv = 1'b1;
    hold(half);
  endtask
  task automatic tx_byte(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, nak);
  endtask
  task automatic rx_byte(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nak, r);
  endtask
endmodule

/* File: bench/bcr_serial_access_test.sv */
// self-checking bench of the serial register access block
`timescale 1ns/1ps
`include "bcr_map.svh"
module bcr_serial_access_test;
  localparam logic [6:0] DEV = {`BCR_ADDR_HI, 3'h5};
  logic                  clk = 1'b0;
  logic                  nrst = 1'b0;
  logic                  scl;
  logic                  m_sda;
  logic                  sda_o;
  logic                  sda_oe_n;
  wire                   sda_w = m_sda & (sda_oe_n | sda_o);
  bcr_pkg::bcr_conv_type conv_in = '0;
  logic                  conv_valid = 1'b0;
  logic                  conv_ready;
  logic [11:0]           flag_in = 12'hA5C;
  logic                  q_pop;
  logic                  q_ovf;
  logic                  q_empty;
  logic [7:0]            hi1, hi2, lo1, lo2;
  logic [9:0]            fine1, fine2;
  bcr_pkg::bcr_wr_type   wr_evt;
  int                    n_fail = 0;
  int                    n_tests = 0;
  logic                  nak;
  always #2.5 clk = ~clk;

  bcr_serial_access uut (.clk(clk), .nrst(nrst), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .addr_strap_bit2(1'b1), .addr_strap_bit1(1'b0), .addr_strap_bit0(1'b1),
    .conv_in(conv_in), .conv_valid(conv_valid), .conv_ready(conv_ready),
    .flag_in(flag_in), .queue_pop(q_pop), .queue_ovf(q_ovf),
    .queue_empty(q_empty), .coarse_high_writethru_ch1(hi1),
    .coarse_high_writethru_ch2(hi2), .coarse_low_writethru_ch1(lo1),
    .coarse_low_writethru_ch2(lo2), .fine_writethru_calib_ch1(fine1),
    .fine_writethru_calib_ch2(fine2), .wr_evt(wr_evt));
  bcr_bus_master m (.clk(clk), .sda(sda_w), .scl(scl), .sda_drv(m_sda));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic open(input logic rw);
    m.start();
    m.tx_byte({DEV, rw}, nak);
    check("addr ack", {15'h0, nak}, 16'h0000);
  endtask
  task automatic put(input logic [7:0] b);
    m.tx_byte(b, nak);
    check("byte ack", {15'h0, nak}, 16'h0000);
  endtask
  task automatic wr_word(input logic [3:0] sel, input logic [15:0] d);
    put({4'h0, sel});
    put(d[15:8]);
    put(d[7:0]);
  endtask
  task automatic get(input logic last, output logic [15:0] w);
    m.rx_byte(1'b0, w[15:8]);
    m.rx_byte(last, w[7:0]);
  endtask
  function automatic logic [15:0] qw(input int i);
    return {1'b0, 3'(i % 7), 12'(12'h100 + i)};
  endfunction

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] w;
    logic [3:0]  sels[5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
    logic [15:0] dats[5] = '{16'hFF34, 16'h5A56, 16'h0078, 16'hFFFF, 16'h0155};
    logic [15:0] seen[5];
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    check("hi1", {8'h00, hi1}, 16'h0000);
    check("lo2", {8'h00, lo2}, 16'h0000);
    check("fine2", {6'h00, fine2}, 16'h0000);
    check("empty", {15'h0, q_empty}, 16'h0001);
    $display("test reset done");
    open(1'b0);
    wr_word(`BCR_SEL_HI_CH1, 16'h12AB);
    m.stop();
    check("hi1", {8'h00, hi1}, 16'h00AB);
    open(1'b0);
    for (int i = 0; i < 5; i++) wr_word(sels[i], dats[i]);
    m.stop();
    seen = '{{8'h00, hi2}, {8'h00, lo1}, {8'h00, lo2}, {6'h00, fine1},
             {6'h00, fine2}};
    for (int i = 0; i < 5; i++)
      check("block", seen[i], i < 3 ?
        {8'h00, dats[i][7:0]} : {6'h00, dats[i][9:0]});
    m.start();
    m.tx_byte({`BCR_ADDR_HI, 3'h4, 1'b0}, nak);
    m.stop();
    check("foreign addr", {15'h0, nak}, 16'h0001);
    $display("test writes done");
    open(1'b0);
    put({4'h0, `BCR_SEL_LO_CH1});
    open(1'b1);
    get(1'b1, w);
    m.stop();
    check("read5", w, 16'h0056);
    m.half = 10;
    open(1'b1);
    get(1'b1, w);
    m.stop();
    m.half = 6;
    check("read3", w, 16'h0056);
    $display("test reads done");
    @(negedge clk);
    conv_in = '{src: `BCR_SRC_RESERVED, result: 12'h123};
    conv_valid = 1'b1;
    @(negedge clk);
    conv_valid = 1'b0;
    repeat (3) @(negedge clk);
    check("src7 dropped", {15'h0, q_empty}, 16'h0001);
    open(1'b0);
    put({4'h0, `BCR_SEL_QUEUE});
    open(1'b1);
    get(1'b1, w);
    m.stop();
    check("empty word", w, {`BCR_TAG_EMPTY, flag_in});
    check("empty kept", {15'h0, q_empty}, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      conv_in = 15'(qw(i));
      conv_valid = 1'b1;
    end
    // push held on a full queue so the pop meets an overflow
    open(1'b1);
    get(1'b1, w);
    m.stop();
    conv_valid = 1'b0;
    check("overflow word", w, {`BCR_TAG_CORRUPT, 12'h100});
    open(1'b1);
    for (int i = 1; i <= 8; i++) begin
      get(1'b0, w);
      check("queue word", w, qw(i > 7 ? 7 : i));
    end
    get(1'b1, w);
    m.stop();
    check("drained", w, {`BCR_TAG_EMPTY, flag_in});
    $display("test queue done");
    report_and_stop();
  end

  initial begin
    #300000;
    n_fail++;
    report_and_stop();
  end
endmodule
